// ### ibea_ctrl.sv
// two-wire controller core: bus error, repeated start, arbitration, AXI4-Lite registers
// assumes open-drain lines resolved outside; scl_i and sda_i are asynchronous
//
// Decided for this implementation: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps

module ibea_ctrl
    import ibea_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite slave
    input wire logic awvalid,
    output logic awready,
    input wire logic [7:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [7:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // two-wire bus pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // interrupt
    output logic irq
);
    ibea_state_s s, n;
    logic rise, fall, start_det, stop_det, illegal, berr_ev, my_tx, arb_ev, do_wr, wr_ctrl;
    logic [7:0] rd_code;

    assign rise = s.scl_s2 & ~s.scl_p;
    assign fall = ~s.scl_s2 & s.scl_p;
    assign start_det = s.scl_s2 & s.scl_p & s.sda_p & ~s.sda_s2;
    assign stop_det = s.scl_s2 & s.scl_p & ~s.sda_p & s.sda_s2;
    assign illegal = (s.ph == PH_ADDR || s.ph == PH_DATA) && s.bitcnt != 4'h0;
    assign berr_ev = (start_det | stop_det) & illegal;
    assign my_tx = !s.bitcnt[3] && s.master && s.ms == MS_CLK && (s.ph == PH_ADDR || !s.rd);
    // identical bits never differ, so several masters all carry on
    assign arb_ev = rise && !start_det && !stop_det && my_tx && s.tx[~s.bitcnt[2:0]]
        && !s.sda_s2;
    assign do_wr = s.aw_have & s.w_have & ~s.bvalid;
    assign wr_ctrl = do_wr && s.awaddr == A_CTRL && s.wstrb0 && s.wdata[CB_FLAG];
    assign rd_code = s.flag ? (s.code & STAT_CODE_MASK) : ST_IDLE;

    always_comb
    begin
        n = s;
        n.scl_s1 = scl_i;
        n.scl_s2 = s.scl_s1;
        n.scl_p = s.scl_s2;
        n.sda_s1 = sda_i;
        n.sda_s2 = s.sda_s1;
        n.sda_p = s.sda_s2;
        // register bus
        if (awvalid && s.awready)
        begin
            n.aw_have = 1'b1;
            n.awaddr = awaddr;
        end
        if (wvalid && s.wready)
        begin
            n.w_have = 1'b1;
            n.wdata = wdata[7:0];
            n.wstrb0 = wstrb[0];
        end
        if (s.bvalid && bready)
            n.bvalid = 1'b0;
        if (do_wr)
        begin
            n.aw_have = 1'b0;
            n.w_have = 1'b0;
            n.bvalid = 1'b1;
            n.bresp = RESP_OKAY;
            if (s.awaddr == A_CTRL)
            begin
                if (s.wstrb0)
                begin
                    n.ack_en = s.wdata[CB_ACK];
                    n.start_req = s.wdata[CB_START];
                    n.stop_req = s.wdata[CB_STOP];
                end
            end
            else if (s.awaddr == A_STAT)
            begin
                if (s.wstrb0)
                    n.presc = s.wdata[1:0];
            end
            else if (s.awaddr == A_DATA)
            begin
                if (s.wstrb0)
                    n.tx = s.wdata;
            end
            else if (s.awaddr == A_OWN)
            begin
                if (s.wstrb0)
                    n.own = s.wdata[7:1];
            end
            else if (s.awaddr == A_IRQ_MSK)
            begin
                if (s.wstrb0)
                    n.irq_msk = s.wdata[2:0];
            end
            else if (s.awaddr != A_IRQ_ST)
                n.bresp = RESP_SLVERR;
        end
        // while the flag is clear no software action is needed: engine runs on
        if (wr_ctrl)
        begin
            n.flag = 1'b0;
            if (s.addressed && s.rd)
                n.last_byte = ~s.wdata[CB_ACK];
            if (s.ph == PH_ERR && s.wdata[CB_STOP])
            begin
                n.ph = PH_IDLE;
                n.stop_req = 1'b0;
                n.master = 1'b0;
                n.addressed = 1'b0;
                n.ms = MS_NONE;
            end
            else if (s.master && s.wdata[CB_START])
            begin
                n.ms = MS_RSTART;
                n.step = 2'd0;
                n.tmr = 4'h0;
            end
            else if (s.master && s.wdata[CB_STOP])
            begin
                n.ms = MS_STOP;
                n.step = 2'd0;
                n.tmr = 4'h0;
            end
            else if (!s.master && s.wdata[CB_START])
                n.ms = MS_WAITFREE;
        end
        if (s.rvalid && rready)
            n.rvalid = 1'b0;
        if (arvalid && s.arready)
        begin
            n.rvalid = 1'b1;
            n.rresp = RESP_OKAY;
            n.rdata = 32'h0;
            if (araddr == A_CTRL)
                n.rdata[7:0] = {s.flag, s.ack_en, s.start_req, s.stop_req, 4'h0};
            else if (araddr == A_STAT)
                n.rdata[7:0] = {rd_code[7:3], 1'b0, s.presc};
            else if (araddr == A_DATA)
                n.rdata[7:0] = s.rx;
            else if (araddr == A_OWN)
                n.rdata[7:0] = {s.own, 1'b0};
            else if (araddr == A_IRQ_ST)
            begin
                n.rdata[2:0] = s.irq_st;
                n.irq_st = 3'h0;
            end
            else if (araddr == A_IRQ_MSK)
                n.rdata[2:0] = s.irq_msk;
            else
                n.rresp = RESP_SLVERR;
        end
        // bus monitor and bit engine
        if (start_det || stop_det)
        begin
            n.busy = start_det;
            n.bitcnt = 4'h0;
            n.mid = 1'b0;
            if (illegal)
            begin
                n.ph = PH_ERR;
                n.master = 1'b0;
                n.addressed = 1'b0;
                n.ms = MS_NONE;
                n.scl_low = 1'b0;
                n.flag = 1'b1;
                n.code = ST_BUSERR;
                n.irq_st[IB_BERR] = 1'b1;
            end
            else if (start_det)
            begin
                n.ph = PH_ADDR;
                n.addressed = 1'b0;
                n.arb_lost = 1'b0;
            end
            else
            begin
                if (s.addressed && !s.rd && s.ph == PH_DATA)
                begin
                    n.flag = 1'b1;
                    n.code = ST_SR_STOP;
                end
                if (s.ph != PH_ERR)
                    n.ph = PH_IDLE;
                n.addressed = 1'b0;
            end
        end
        else if (s.ph == PH_ADDR || s.ph == PH_DATA)
        begin
            if (rise)
            begin
                n.mid = 1'b1;
                if (s.bitcnt[3])
                    n.got_ack = ~s.sda_s2;
                else
                    n.rx = {s.rx[6:0], s.sda_s2};
                if (arb_ev)
                begin
                    n.master = 1'b0;
                    n.ms = MS_NONE;
                    n.scl_low = 1'b0;
                    if (s.ph == PH_ADDR && s.bitcnt != 4'd7)
                        n.arb_lost = 1'b1;
                    else
                    begin
                        n.ph = PH_IDLE;
                        n.flag = 1'b1;
                        n.code = ST_ARB_LOST;
                        n.irq_st[IB_ARB] = 1'b1;
                    end
                end
            end
            if (fall && s.mid)
            begin
                n.mid = 1'b0;
                n.bitcnt = s.bitcnt + 4'h1;
                if (s.bitcnt == 4'd7 && s.ph == PH_ADDR)
                begin
                    n.rd = s.master ? s.tx[0] : s.rx[0];
                    n.addressed = !s.master && s.rx[7:1] == s.own && s.ack_en;
                end
                if (s.bitcnt[3])
                begin
                    n.bitcnt = 4'h0;
                    n.flag = 1'b1;
                    n.ph = PH_DATA;
                    if (s.master && s.ph == PH_ADDR)
                        n.code = s.rd ? (s.got_ack ? ST_MR_SLA_ACK : ST_MR_SLA_NACK)
                            : (s.got_ack ? ST_MT_SLA_ACK : ST_MT_SLA_NACK);
                    else if (s.master)
                        n.code = s.rd ? (s.got_ack ? ST_MR_DAT_ACK : ST_MR_DAT_NACK)
                            : (s.got_ack ? ST_MT_DAT_ACK : ST_MT_DAT_NACK);
                    else if (s.ph == PH_ADDR && s.addressed)
                    begin
                        n.last_byte = 1'b0;
                        n.code = s.rd ? (s.arb_lost ? ST_ARB_ST : ST_ST_SLA)
                            : (s.arb_lost ? ST_ARB_SR : ST_SR_SLA);
                    end
                    else if (s.ph == PH_ADDR)
                    begin
                        n.ph = PH_IDLE;
                        n.flag = s.arb_lost;
                        n.code = ST_ARB_LOST;
                        n.irq_st[IB_ARB] = s.arb_lost;
                    end
                    else if (s.rd)
                    begin
                        n.code = !s.got_ack ? ST_ST_DAT_NACK
                            : (s.last_byte ? ST_ST_LAST_ACK : ST_ST_DAT_ACK);
                        if (!s.got_ack || s.last_byte)
                        begin
                            n.addressed = 1'b0;
                            n.ph = PH_IDLE;
                        end
                    end
                    else
                    begin
                        n.code = s.got_ack ? ST_SR_DAT_ACK : ST_SR_DAT_NACK;
                        if (!s.got_ack)
                        begin
                            n.addressed = 1'b0;
                            n.ph = PH_IDLE;
                        end
                    end
                    if (!s.master && s.ph == PH_ADDR)
                        n.arb_lost = 1'b0;
                end
            end
        end
        // master clock and condition generator
        case (s.ms)
            MS_WAITFREE:
                if (!s.busy)
                begin
                    n.ms = MS_START;
                    n.tmr = 4'h0;
                    n.scl_low = 1'b0;
                end
            MS_START:
            begin
                n.tmr = s.tmr + 4'h1;
                if (s.tmr == HALF_CNT)
                begin
                    n.tmr = 4'h0;
                    n.scl_low = 1'b1;
                    n.ms = MS_CLK;
                    n.master = 1'b1;
                    n.flag = 1'b1;
                    n.code = s.master ? ST_RSTART : ST_START;
                    n.start_req = 1'b0;
                end
            end
            MS_RSTART, MS_STOP:
            begin
                if (s.step == 2'd0 || s.scl_s2)
                    n.tmr = s.tmr + 4'h1;
                if (s.tmr == HALF_CNT)
                begin
                    n.tmr = 4'h0;
                    n.step = s.step + 2'd1;
                    n.scl_low = 1'b0;
                    if (s.step == 2'd1 && s.ms == MS_RSTART)
                        n.ms = MS_START;
                    else if (s.step == 2'd2)
                    begin
                        n.ms = s.start_req ? MS_WAITFREE : MS_NONE;
                        n.master = 1'b0;
                        n.stop_req = 1'b0;
                        n.ph = PH_IDLE;
                    end
                end
            end
            MS_CLK:
                if (s.flag)
                begin
                    n.scl_low = 1'b1;
                    n.tmr = 4'h0;
                end
                else if (s.scl_low || s.scl_s2)
                begin
                    n.tmr = s.tmr + 4'h1;
                    if (s.tmr == HALF_CNT)
                    begin
                        n.tmr = 4'h0;
                        n.scl_low = ~s.scl_low;
                    end
                end
            default:
                n.scl_low = 1'b0;
        endcase
        // pin drive, interrupt and bus handshake outputs
        if (n.ms == MS_START || n.ms == MS_RSTART || n.ms == MS_STOP)
            n.sda_oe = n.ms == MS_START || (n.ms == MS_STOP && n.step != 2'd2);
        else if (n.ph == PH_ADDR || n.ph == PH_DATA)
        begin
            if (!n.bitcnt[3])
                n.sda_oe = ((n.master && (n.ph == PH_ADDR || !n.rd))
                    || (n.addressed && n.rd && n.ph == PH_DATA)) && !n.tx[~n.bitcnt[2:0]];
            else
                n.sda_oe = (n.ph == PH_ADDR && n.addressed)
                    || (n.ph == PH_DATA && n.ack_en && n.rd == n.master
                    && (n.master || n.addressed));
        end
        else
            n.sda_oe = 1'b0;
        n.scl_oe = (n.ms != MS_NONE && n.ms != MS_WAITFREE) ? n.scl_low
            : (n.flag && n.addressed && n.ph == PH_DATA);
        if (n.flag && !s.flag)
            n.irq_st[IB_DONE] = 1'b1;
        n.irq = |(n.irq_st & n.irq_msk);
        n.awready = ~n.aw_have & ~n.bvalid;
        n.wready = ~n.w_have & ~n.bvalid;
        n.arready = ~n.rvalid;
        n.zero = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s <= '0;
            s.scl_s1 <= 1'b1;
            s.scl_s2 <= 1'b1;
            s.scl_p <= 1'b1;
            s.sda_s1 <= 1'b1;
            s.sda_s2 <= 1'b1;
            s.sda_p <= 1'b1;
            s.own <= OWN_RST;
        end
        else
            s <= n;
    end

    assign awready = s.awready;
    assign wready = s.wready;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign arready = s.arready;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;
    assign scl_o = s.zero;
    assign sda_o = s.zero;
    assign scl_oe = s.scl_oe;
    assign sda_oe = s.sda_oe;
    assign irq = s.irq;

    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    sequence s_recover;
        wr_ctrl && s.wdata[CB_STOP] && !s.wdata[CB_START] && s.ph == PH_ERR;
    endsequence
    sequence s_addr_read_won;
        fall && s.mid && s.bitcnt == 4'd8 && s.ph == PH_ADDR && !s.master
            && s.addressed && s.rd && s.arb_lost;
    endsequence

    AST_IDLE_CODE: assert property (arvalid && s.arready && araddr == A_STAT && !s.flag
        |=> s.rdata[7:3] == ST_IDLE[7:3]) else $error("idle status code wrong");
    AST_BERR_CODE: assert property (berr_ev |=> s.code == ST_BUSERR)
        else $error("bus error code missing");
    AST_BERR_DET: assert property (berr_ev |=> s.ph == PH_ERR)
        else $error("illegal condition not flagged");
    AST_BERR_FLAG: assert property (berr_ev |=> s.flag && s.irq_st[IB_BERR])
        else $error("bus error did not set flag");
    AST_RECOVER: assert property (s_recover |=> s.ph == PH_IDLE && !s.stop_req
        && !s.start_req && s.ack_en == $past(s.wdata[CB_ACK]))
        else $error("recovery state wrong");
    AST_RELEASE: assert property (s.ph == PH_ERR |-> !s.scl_oe && !s.sda_oe)
        else $error("lines driven in bus error");
    AST_RSTART_OWN: assert property (s.ms == MS_START && s.tmr == HALF_CNT && s.master
        |=> s.master && s.code == ST_RSTART ##1 s.master) else $error("ownership lost");
    AST_ARB_LOST: assert property (arb_ev |=> !s.master && !s.sda_oe)
        else $error("loser still drives");
    AST_ARB_SLA: assert property (arb_ev && s.ph == PH_ADDR && s.bitcnt < 4'd7
        |=> s.ph == PH_ADDR && s.arb_lost) else $error("address loss not slave");
    AST_B0: assert property (s_addr_read_won |=> s.flag && s.code == ST_ARB_ST)
        else $error("lost then read address code wrong");
    AST_NO_ACK: assert property (fall && s.mid && s.bitcnt == 4'd7 && s.ph == PH_ADDR
        && !s.master && !s.ack_en |=> !s.addressed) else $error("address answered");
endmodule

// ### ibea_pkg.sv
// constants, types and state layout of the two-wire bus error and arbitration block
// assumes a 40 MHz system clock and an AXI4-Lite register master
package ibea_pkg;
    localparam int CLK_NS = 25;
    localparam int LINK_HALF_NS = 100;
    localparam int HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [3:0] HALF_CNT = 4'(HALF_CYC - 1);
    // byte addresses
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_STAT = 8'h04;
    localparam logic [7:0] A_DATA = 8'h08;
    localparam logic [7:0] A_OWN = 8'h0C;
    localparam logic [7:0] A_IRQ_ST = 8'h10;
    localparam logic [7:0] A_IRQ_MSK = 8'h14;
    // serial_control_register bits
    localparam int CB_FLAG = 7;
    localparam int CB_ACK = 6;
    localparam int CB_START = 5;
    localparam int CB_STOP = 4;
    // irq status and mask bits
    localparam int IB_DONE = 0;
    localparam int IB_BERR = 1;
    localparam int IB_ARB = 2;
    localparam logic [6:0] OWN_RST = 7'h00;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
    // status codes, prescaler bits excluded
    localparam logic [7:0] STAT_CODE_MASK = 8'hF8;
    localparam logic [7:0] ST_IDLE = 8'hF8;
    localparam logic [7:0] ST_BUSERR = 8'h00;
    localparam logic [7:0] ST_START = 8'h08;
    localparam logic [7:0] ST_RSTART = 8'h10;
    localparam logic [7:0] ST_MT_SLA_ACK = 8'h18;
    localparam logic [7:0] ST_MT_SLA_NACK = 8'h20;
    localparam logic [7:0] ST_MT_DAT_ACK = 8'h28;
    localparam logic [7:0] ST_MT_DAT_NACK = 8'h30;
    localparam logic [7:0] ST_ARB_LOST = 8'h38;
    localparam logic [7:0] ST_MR_SLA_ACK = 8'h40;
    localparam logic [7:0] ST_MR_SLA_NACK = 8'h48;
    localparam logic [7:0] ST_MR_DAT_ACK = 8'h50;
    localparam logic [7:0] ST_MR_DAT_NACK = 8'h58;
    localparam logic [7:0] ST_SR_SLA = 8'h60;
    localparam logic [7:0] ST_ARB_SR = 8'h68;
    localparam logic [7:0] ST_SR_DAT_ACK = 8'h80;
    localparam logic [7:0] ST_SR_DAT_NACK = 8'h88;
    localparam logic [7:0] ST_SR_STOP = 8'hA0;
    localparam logic [7:0] ST_ST_SLA = 8'hA8;
    localparam logic [7:0] ST_ARB_ST = 8'hB0;
    localparam logic [7:0] ST_ST_DAT_ACK = 8'hB8;
    localparam logic [7:0] ST_ST_DAT_NACK = 8'hC0;
    localparam logic [7:0] ST_ST_LAST_ACK = 8'hC8;

    typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_ERR} ibea_ph_e;
    typedef enum logic [2:0] {MS_NONE, MS_WAITFREE, MS_START, MS_RSTART, MS_CLK, MS_STOP}
        ibea_ms_e;

    typedef struct packed {
        logic scl_s1, scl_s2, scl_p, sda_s1, sda_s2, sda_p;
        logic busy;
        ibea_ph_e ph;
        logic [3:0] bitcnt;
        logic mid;
        logic [7:0] rx;
        logic [7:0] tx;
        logic master, addressed, rd, got_ack, arb_lost, last_byte;
        ibea_ms_e ms;
        logic [3:0] tmr;
        logic [1:0] step;
        logic scl_low;
        logic flag, ack_en, start_req, stop_req;
        logic [7:0] code;
        logic [1:0] presc;
        logic [6:0] own;
        logic [2:0] irq_st, irq_msk;
        logic awready, wready, bvalid, arready, rvalid, aw_have, w_have, wstrb0;
        logic [1:0] bresp, rresp;
        logic [31:0] rdata;
        logic [7:0] awaddr, wdata;
        logic scl_oe, sda_oe, irq, zero;
    } ibea_state_s;
endpackage

// ### ibea_peer.sv
// two-wire bus peer: master by tasks, slave that acknowledges the first byte after each start
// assumes the bench resolves both open-drain lines with pull-ups
`timescale 1ns/1ps
module ibea_peer (
    // resolved lines
    input wire logic scl,
    input wire logic sda,
    // open-drain pulls
    output logic scl_oe,
    output logic sda_oe
);
    logic ack_on = 1'b0;
    int n = 0;
    initial scl_oe = 1'b0;
    initial sda_oe = 1'b0;
    always @(negedge sda) if (scl) n = 0;
    always @(posedge scl) n = n + 1;
    // pull data low through the ack bit only
    always @(negedge scl)
    begin
        if (ack_on && n == 8) sda_oe <= #50 1'b1;
        if (ack_on && n == 9) sda_oe <= #50 1'b0;
    end
    task automatic put(input logic c, input logic d);
        scl_oe <= !c;
        sda_oe <= !d;
        #100;
    endtask
    task automatic start();
        put(1'b1, 1'b1);
        put(1'b1, 1'b0);
        put(1'b0, 1'b0);
    endtask
    task automatic stop();
        put(1'b0, 1'b0);
        put(1'b1, 1'b0);
        put(1'b1, 1'b1);
    endtask
endmodule

// ### testbench.sv
// self-checking bench: AXI4-Lite register tasks and a two-wire bus peer
// assumes the controller core and the peer model are compiled first
`timescale 1ns/1ps
module testbench import ibea_pkg::*;;
    localparam logic [7:0] ADR = 8'h43;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, d;
    logic [31:0] wdata = 32'h00000000, rdata;
    logic awready, wready, bvalid, arready, rvalid, scl_oe, sda_oe, irq, p_scl, p_sda, a;
    logic [1:0] bresp, rresp, r;
    wire scl = !(scl_oe || p_scl);
    wire sda = !(sda_oe || p_sda);
    int n_errors = 0, n_checks = 0;
    initial forever #12.5 aclk = ~aclk;
    ibea_ctrl dut (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(4'hF),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready),
        .rdata(rdata), .rresp(rresp), .scl_i(scl), .scl_o(), .scl_oe(scl_oe),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .irq(irq));
    ibea_peer peer (.scl(scl), .sda(sda), .scl_oe(p_scl), .sda_oe(p_sda));
    task automatic chk(input logic ok, input string m);
        n_checks++;
        if (ok !== 1'b1)
        begin
            n_errors++;
            $display("mismatch at %0t: %s", $time, m);
        end
    endtask
    task automatic wr(input logic [7:0] ad, input logic [7:0] dt);
        int t;
        @(posedge aclk);
        awaddr <= ad;
        wdata <= {24'h000000, dt};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge aclk);
            t++;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end
        while (bvalid !== 1'b1 && t < 100);
        bready <= 1'b0;
        chk(t < 100, "write hang");
    endtask
    task automatic rd(input logic [7:0] ad, output logic [7:0] dt, output logic [1:0] rs);
        int t;
        @(posedge aclk);
        araddr <= ad;
        arvalid <= 1'b1;
        rready <= 1'b1;
        t = 0;
        do
        begin
            @(posedge aclk);
            t++;
            if (arready) arvalid <= 1'b0;
        end
        while (rvalid !== 1'b1 && t < 100);
        dt = rdata[7:0];
        rs = rresp;
        rready <= 1'b0;
        chk(t < 100, "read hang");
    endtask
    task automatic rc(input logic [7:0] ad, input logic [7:0] e);
        rd(ad, d, r);
        chk(d === e && r === RESP_OKAY, "register value");
    endtask
    task automatic st(input logic [7:0] c);
        rd(A_STAT, d, r);
        chk((d & STAT_CODE_MASK) === c, "status code");
    endtask
    task automatic wflag();
        int t;
        t = 0;
        do
        begin
            rd(A_CTRL, d, r);
            t++;
        end
        while (d[CB_FLAG] !== 1'b1 && t < 300);
        chk(t < 300, "flag never set");
    endtask
    task automatic pbit(input logic b);
        peer.put(1'b0, b);
        peer.put(1'b1, b);
    endtask
    task automatic pframe(output logic ack);
        peer.start();
        for (int i = 7; i >= 0; i--) pbit(ADR[i]);
        pbit(1'b1);
        ack = sda;
        peer.put(1'b0, 1'b1);
    endtask
    task automatic final_report();
        if (n_errors == 0 && n_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        #1000000;
        n_errors++;
        final_report();
    end
    initial
    begin
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        wr(A_STAT, 8'h03);
        rc(A_STAT, 8'hFB);
        st(ST_IDLE);
        rd(8'h40, d, r);
        chk(r === RESP_SLVERR, "unmapped read");
        peer.ack_on = 1'b1;
        wr(A_CTRL, 8'hA0);
        wflag();
        st(ST_START);
        wr(A_DATA, 8'hA0);
        wr(A_CTRL, 8'h80);
        wflag();
        st(ST_MT_SLA_ACK);
        wr(A_CTRL, 8'hA0);
        wflag();
        st(ST_RSTART);
        wr(A_DATA, 8'hA1);
        wr(A_CTRL, 8'h80);
        wflag();
        st(ST_MR_SLA_ACK);
        wr(A_CTRL, 8'h90);
        peer.ack_on = 1'b0;
        st(ST_IDLE);
        rd(A_IRQ_ST, d, r);
        wr(A_IRQ_MSK, 8'h02);
        chk(irq === 1'b0, "irq while clear");
        repeat (20) @(posedge aclk);
        peer.start();
        repeat (3) pbit(1'b1);
        peer.stop();
        wflag();
        st(ST_BUSERR);
        chk(scl_oe === 1'b0 && sda_oe === 1'b0, "lines held");
        chk(irq === 1'b1, "irq not raised");
        rd(A_IRQ_ST, d, r);
        chk(d[IB_BERR] === 1'b1, "error event missing");
        wr(A_CTRL, 8'hD0);
        chk(irq === 1'b0, "irq not cleared");
        rc(A_CTRL, 8'h40);
        chk(scl_oe === 1'b0 && sda_oe === 1'b0, "lines held");
        st(ST_IDLE);
        wr(A_OWN, 8'h42);
        wr(A_CTRL, 8'h00);
        pframe(a);
        chk(a === 1'b1, "answered while disabled");
        peer.stop();
        st(ST_IDLE);
        wr(A_CTRL, 8'h40);
        pframe(a);
        chk(a === 1'b0, "own address not answered");
        wflag();
        st(ST_ST_SLA);
        wr(A_CTRL, 8'h80);
        peer.start();
        peer.stop();
        // lose arbitration in the first address bit, then get addressed for read
        wr(A_DATA, 8'hC0);
        wr(A_CTRL, 8'hE0);
        wflag();
        st(ST_START);
        peer.put(1'b1, 1'b0);
        wr(A_CTRL, 8'hC0);
        @(posedge scl);
        #100;
        for (int i = 6; i >= 0; i--) pbit(ADR[i]);
        pbit(1'b1);
        chk(sda === 1'b0, "lost master not addressed");
        peer.put(1'b0, 1'b1);
        wflag();
        st(ST_ARB_ST);
        final_report();
    end
endmodule
